// [hw/asr_pkg.sv]
// Package for the asynchronous SRAM host controller
package asr_pkg;
   // ===================================================
   // Widths and timing (slowest grade, 15 ns)
   // ===================================================
   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   localparam int CLK_PS = 5000;
   localparam int CYCLE_TIME_PS = 15000;       // Write and read cycle time
   localparam int ACCESS_TIME_PS = 15000;      // Address access time
   localparam int ADDR_SETUP_PS = 10000;       // Address and select to write end
   localparam int DATA_SETUP_MIN_PS = 7000;
   localparam int DATA_HOLD_MIN_PS = 0;
   localparam int WR_PULSE_MIN_OE_HIGH_PS = 10000;
   localparam int WR_PULSE_MIN_OE_LOW_PS = 11000;
   localparam int RELEASE_MAX_PS = 6000;       // Output release after write falls
   localparam int WR_RISE_TO_DRIVE_MIN_PS = 0;
   localparam int CNT_W = 4;

   function automatic logic [CNT_W-1:0] ps_to_cyc(input int ps);
      int c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      if (c < 1) c = 1;
      return CNT_W'(c);
   endfunction

   // Write pulse covers release, data setup and both pulse minima
   localparam logic [CNT_W-1:0] WR_PULSE_CYC = ps_to_cyc(WR_PULSE_MIN_OE_LOW_PS);
   localparam logic [CNT_W-1:0] RELEASE_CYC = ps_to_cyc(RELEASE_MAX_PS);
   localparam logic [CNT_W-1:0] ADDR_SETUP_CYC = ps_to_cyc(ADDR_SETUP_PS);
   localparam logic [CNT_W-1:0] CYCLE_CYC = ps_to_cyc(CYCLE_TIME_PS);
   // Read adds one sampling margin and both synchroniser stages to the access time
   localparam logic [CNT_W-1:0] READ_CYC = ps_to_cyc(ACCESS_TIME_PS) + 4'h3;
   localparam logic [CNT_W-1:0] HOLD_CYC = ps_to_cyc(DATA_HOLD_MIN_PS);
   localparam logic [CNT_W-1:0] DATA_SETUP_CYC = ps_to_cyc(DATA_SETUP_MIN_PS);

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asr_req_t;

   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] rdata;
   } asr_rsp_t;

   typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_RECOVER} asr_state_t;
endpackage

// [hw/asr_ctrl.sv]
// Host controller driving a 256K x 8 asynchronous SRAM
`timescale 1ns/10ps
`default_nettype none
module asr_ctrl import asr_pkg::*; (
   input  wire logic             clk_sys,      // 200 MHz clock
   input  wire logic             rst,          // Async reset, active high
   input  wire logic             req_valid,    // Request strobe
   input  wire asr_req_t         req,          // Request fields
   output logic                  req_ready,    // Idle, request taken
   output asr_rsp_t              rsp,          // Read data pulse
   output logic                  ce_n,         // Chip select
   output logic                  oe_n,         // Output enable
   output logic                  we_n,         // Write enable
   output logic [ADDR_W-1:0]     word_addr,    // Address pins
   input  wire logic [DATA_W-1:0] byte_bus_i,  // Data bus in
   output logic [DATA_W-1:0]     byte_bus_o,   // Data bus out
   output logic                  byte_bus_oe   // Host drives data bus
);
   asr_state_t       state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [DATA_W-1:0] din_s1_reg;
   logic [DATA_W-1:0] din_s2_reg;
   logic [CNT_W-1:0] we_low_cnt_reg;
   logic [CNT_W-1:0] drive_cnt_reg;
   logic [CNT_W-1:0] desel_cnt_reg;
   logic [CNT_W-1:0] rd_sel_cnt_reg;

   // ===================================================
   // Data bus synchroniser
   // ===================================================
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         din_s1_reg <= 8'h00;
         din_s2_reg <= 8'h00;
      end else begin
         din_s1_reg <= byte_bus_i;
         din_s2_reg <= din_s1_reg;
      end
   end

   // ===================================================
   // Sequencer
   // ===================================================
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 4'h0;
         req_ready   <= 1'b0;
         rsp         <= '0;
         ce_n        <= 1'b1;
         oe_n        <= 1'b1;
         we_n        <= 1'b1;
         word_addr   <= 18'h00000;
         byte_bus_o  <= 8'h00;
         byte_bus_oe <= 1'b0;
      end else begin
         rsp.valid <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               req_ready <= 1'b1;
               ce_n      <= 1'b1;
               oe_n      <= 1'b1;
               we_n      <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  word_addr <= req.addr;
                  ce_n      <= 1'b0;
                  if (req.we) begin
                     byte_bus_o <= req.wdata;
                     cnt_reg    <= ADDR_SETUP_CYC - WR_PULSE_CYC + 4'h1;
                     state_reg  <= ST_WR_SETUP;
                  end else begin
                     oe_n      <= 1'b0;
                     cnt_reg   <= READ_CYC;
                     state_reg <= ST_RD;
                  end
               end
            end
            ST_RD: begin
               we_n <= 1'b1;
               if (cnt_reg == 4'h1) begin
                  rsp.valid <= 1'b1;
                  rsp.rdata <= din_s2_reg;
                  ce_n      <= 1'b1;
                  oe_n      <= 1'b1;
                  cnt_reg   <= CYCLE_CYC;
                  state_reg <= ST_RECOVER;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_WR_SETUP: begin
               if (cnt_reg <= 4'h1) begin
                  we_n      <= 1'b0;
                  cnt_reg   <= WR_PULSE_CYC;
                  state_reg <= ST_WR_PULSE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_WR_PULSE: begin
               // Output enable stays high in a write, so the memory is off the bus;
               // drive early enough to meet the data setup before the pulse ends
               if (cnt_reg == DATA_SETUP_CYC + 4'h1) begin
                  byte_bus_oe <= 1'b1;
               end
               if (cnt_reg == 4'h1) begin
                  we_n      <= 1'b1;
                  cnt_reg   <= HOLD_CYC;
                  state_reg <= ST_WR_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_WR_HOLD: begin
               byte_bus_oe <= 1'b0;
               ce_n        <= 1'b1;
               cnt_reg     <= CYCLE_CYC;
               state_reg   <= ST_RECOVER;
            end
            ST_RECOVER: begin
               if (cnt_reg <= 4'h1) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ===================================================
   // Protocol timing monitors
   // ===================================================
   // Saturating cycle counters read only by the checks
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
      if (c == 4'hf) begin
         return c;
      end
      return c + 4'h1;
   endfunction

   // Cycles with the write strobe low
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         we_low_cnt_reg <= 4'h0;
      end else if (!we_n) begin
         we_low_cnt_reg <= sat_inc(we_low_cnt_reg);
      end else begin
         we_low_cnt_reg <= 4'h0;
      end
   end

   // Cycles with write data on the bus inside the pulse
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         drive_cnt_reg <= 4'h0;
      end else if (byte_bus_oe && !we_n) begin
         drive_cnt_reg <= sat_inc(drive_cnt_reg);
      end else begin
         drive_cnt_reg <= 4'h0;
      end
   end

   // Cycles deselected; reset counts as a long gap
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         desel_cnt_reg <= CYCLE_CYC;
      end else if (ce_n) begin
         desel_cnt_reg <= sat_inc(desel_cnt_reg);
      end else begin
         desel_cnt_reg <= 4'h0;
      end
   end

   // Cycles with select and output enable both low
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_sel_cnt_reg <= 4'h0;
      end else if (!ce_n && !oe_n) begin
         rd_sel_cnt_reg <= sat_inc(rd_sel_cnt_reg);
      end else begin
         rd_sel_cnt_reg <= 4'h0;
      end
   end

   // ===================================================
   // Checks
   // ===================================================
   a_read_no_write: assert property (@(posedge clk_sys) disable iff (rst)
      (!oe_n && !ce_n) |-> we_n) else $error("write strobe low during read");
   a_no_bus_clash: assert property (@(posedge clk_sys) disable iff (rst)
      byte_bus_oe |-> oe_n) else $error("bus driven while memory may drive");
   a_write_pulse_len: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(we_n) |-> !we_n [*3]) else $error("write pulse too short");
   a_data_stable_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      (!we_n && $past(!we_n)) |-> $stable(byte_bus_o)) else $error("write data moved in pulse");
   a_addr_stable_write: assert property (@(posedge clk_sys) disable iff (rst)
      (!ce_n && $past(!ce_n)) |-> $stable(word_addr)) else $error("address moved in access");
   a_hold_after_end: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(we_n) |-> byte_bus_oe && !ce_n) else $error("data or select dropped with write end");
   a_ce_before_we: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(we_n) |-> $past(!ce_n)) else $error("write started before select");
   a_cycle_spacing: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(ce_n) |-> ce_n [*3]) else $error("cycles too close");
   a_pulse_min_count: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(we_n) |-> we_low_cnt_reg >= WR_PULSE_CYC) else $error("write pulse shorter than minimum");
   a_data_setup_count: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(we_n) |-> drive_cnt_reg >= DATA_SETUP_CYC) else $error("write data driven too late");
   a_deselect_gap: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(ce_n) |-> desel_cnt_reg >= CYCLE_CYC) else $error("select gap shorter than cycle time");
   a_read_wait: assert property (@(posedge clk_sys) disable iff (rst)
      rsp.valid |-> rd_sel_cnt_reg >= READ_CYC) else $error("read answered before data settled");
   a_we_selected: assert property (@(posedge clk_sys) disable iff (rst)
      !we_n |-> !ce_n) else $error("write strobe low while deselected");
   a_write_oe_high: assert property (@(posedge clk_sys) disable iff (rst)
      !we_n |-> oe_n) else $error("output enable low during write");
   a_rsp_single: assert property (@(posedge clk_sys) disable iff (rst)
      rsp.valid |=> !rsp.valid) else $error("read answer longer than one cycle");
   a_desel_no_drive: assert property (@(posedge clk_sys) disable iff (rst)
      ce_n |-> !byte_bus_oe) else $error("bus driven while deselected");
endmodule // asr_ctrl
`default_nettype wire

// [bench/asr_sram_model.sv]
// Behavioural model of the 256K x 8 asynchronous SRAM
`timescale 1ns/10ps
`default_nettype none
module asr_sram_model import asr_pkg::*; #(parameter int ACC_NS = 15) (
   input  wire logic              ce_n,  // Chip select
   input  wire logic              oe_n,  // Output enable
   input  wire logic              we_n,  // Write enable
   input  wire logic [ADDR_W-1:0] addr,  // Address pins
   input  wire logic [DATA_W-1:0] din,   // Wire level
   output logic      [DATA_W-1:0] dq,    // Data offered
   output logic                   drv,   // Model drives wire
   output var logic               viol   // Host timing broken
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] rd_q;
   logic [DATA_W-1:0] rd_d;
   realtime           t_a, t_d, t_c, t_w;
   initial viol = 1'b0;
   assign drv = !ce_n && !oe_n && we_n;
   assign rd_q = mem[addr];
   assign #(ACC_NS) rd_d = rd_q;
   // Released wire shows the inverse, never the last value
   assign dq = drv ? rd_d : ~rd_d;
   always @(addr) t_a = $realtime;
   always @(din) t_d = $realtime;
   always @(negedge ce_n) t_c = $realtime;
   always @(negedge we_n) t_w = $realtime;
   // Store on whichever strobe rises first
   always @(posedge we_n or posedge ce_n)
      if (!(ce_n && we_n)) begin
         mem[addr] = din;
         if ($realtime - t_d < DATA_SETUP_MIN_PS / 1000.0) viol = 1'b1;
         if ($realtime - t_a < ADDR_SETUP_PS / 1000.0) viol = 1'b1;
         if ($realtime - t_c < ADDR_SETUP_PS / 1000.0) viol = 1'b1;
         if ($realtime - t_w < (oe_n ? WR_PULSE_MIN_OE_HIGH_PS : WR_PULSE_MIN_OE_LOW_PS) / 1000.0)
            viol = 1'b1;
      end
endmodule // asr_sram_model
`default_nettype wire

// [bench/asr_ctrl_tb.sv]
// Testbench for the asynchronous SRAM host controller
`timescale 1ns/10ps
`default_nettype none
module asr_ctrl_tb import asr_pkg::*;;
   logic              clk_sys, rst, req_valid, req_ready, ce_n, oe_n, we_n, byte_bus_oe, drv, viol;
   asr_req_t          req;
   asr_rsp_t          rsp;
   logic [ADDR_W-1:0] word_addr;
   logic [ADDR_W-1:0] wr_a [12];
   logic [DATA_W-1:0] bus, byte_bus_o, dq;
   logic [DATA_W-1:0] wr_d [12];
   logic [DATA_W-1:0] exp_q [$];
   int                num_errors = 0, total_checks = 0, seed = 32'h68c8;
   assign bus = byte_bus_oe ? byte_bus_o : dq;
   asr_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp(rsp), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .word_addr(word_addr), .byte_bus_i(bus),
      .byte_bus_o(byte_bus_o), .byte_bus_oe(byte_bus_oe));
   asr_sram_model mem_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(word_addr), .din(bus), .dq(dq),
      .drv(drv), .viol(viol));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic access(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n = 0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= '{we: we, addr: a, wdata: d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      if (req_ready !== 1'b1) begin
         check(8'h0, 8'h1);
         final_report();
      end
      if (!we) exp_q.push_back(d);
      req_valid <= 1'b0;
   endtask
   task automatic drain();
      int n = 0;
      while (exp_q.size() != 0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      if (exp_q.size() != 0) begin
         check(8'h0, 8'h1);
         final_report();
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Compare each read answer with the oldest note, mid-cycle where outputs are settled
   always @(negedge clk_sys) begin
      if (rsp.valid === 1'b1) begin
         if (exp_q.size() == 0) check(8'h0, 8'h1);
         else check(rsp.rdata, exp_q.pop_front());
      end
      if (byte_bus_oe === 1'b1 && drv === 1'b1) check(8'h0, 8'h1);
   end
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check({7'h0, ce_n & oe_n & we_n}, 8'h1);
      for (int i = 0; i < 12; i++) begin
         wr_a[i] = (i == 0) ? 18'h0 : (i == 1) ? 18'h3ffff : {4'(i), 14'($random(seed))};
         wr_d[i] = 8'($random(seed));
         access(1'b1, wr_a[i], wr_d[i]);
      end
      for (int i = 0; i < 12; i++) access(1'b0, wr_a[i], wr_d[i]);
      drain();
      $display("test write and read back done");
      access(1'b1, wr_a[1], ~wr_d[1]);
      access(1'b0, wr_a[1], ~wr_d[1]);
      access(1'b0, wr_a[0], wr_d[0]);
      drain();
      $display("test overwrite done");
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      check({7'h0, ce_n & oe_n & we_n}, 8'h1);
      access(1'b0, wr_a[5], wr_d[5]);
      drain();
      $display("test reset mid-run done");
      check({7'h0, viol}, 8'h0);
      final_report();
   end
endmodule // asr_ctrl_tb
`default_nettype wire
